//--- shared/dma_seq_pkg.sv
// constants for the disk/tape dma handshake sequencer
package dma_seq_pkg;
    // ------------------------------------------------------------
    // output latch bit positions
    // ------------------------------------------------------------
    localparam logic [2:0] LB_ATTN      = 3'h0;
    localparam logic [2:0] LB_DRESET    = 3'h1;
    localparam logic [2:0] LB_HOST_INT  = 3'h2;
    localparam logic [2:0] LB_TAPE_DREQ = 3'h3;
    localparam logic [2:0] LB_ONLINE    = 3'h4;
    localparam logic [2:0] LB_TAPE_INT  = 3'h5;
    localparam logic [2:0] LB_TAPE_RST  = 3'h6;
    localparam logic [2:0] LB_DISK_ACK  = 3'h7;
    localparam logic [7:0] LATCH_RESET  = 8'h00;
    // ------------------------------------------------------------
    // host command codes (thirteen valid)
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_SET_ATTN   = 4'h0;
    localparam logic [3:0] CMD_CLR_ATTN   = 4'h1;
    localparam logic [3:0] CMD_SET_DRST   = 4'h2;
    localparam logic [3:0] CMD_CLR_DRST   = 4'h3;
    localparam logic [3:0] CMD_CLR_INT    = 4'h4;
    localparam logic [3:0] CMD_SET_TDREQ  = 4'h5;
    localparam logic [3:0] CMD_CLR_TDREQ  = 4'h6;
    localparam logic [3:0] CMD_SET_ONLINE = 4'h7;
    localparam logic [3:0] CMD_CLR_ONLINE = 4'h8;
    localparam logic [3:0] CMD_SET_TINT   = 4'h9;
    localparam logic [3:0] CMD_CLR_TINT   = 4'ha;
    localparam logic [3:0] CMD_SET_TRST   = 4'hb;
    localparam logic [3:0] CMD_CLR_TRST   = 4'hc;
    localparam logic [3:0] CMD_LAST       = 4'hc;
    // ------------------------------------------------------------
    // condition mux selects and program addresses
    // ------------------------------------------------------------
    localparam logic [3:0] CS_CMD_VALID = 4'h0;
    localparam logic [3:0] CS_DDMA_ACK  = 4'h1;
    localparam logic [3:0] CS_DISK_REQ  = 4'h2;
    localparam logic [3:0] CS_TAPE_ACK  = 4'h3;
    localparam logic [3:0] CS_TAPE_WR   = 4'h4;
    localparam logic [3:0] CS_TAPE_CMD  = 4'h5;
    localparam logic [3:0] CS_DISK_INT  = 4'h6;
    localparam logic [3:0] CS_TAPE_EXC  = 4'h7;
    localparam logic [3:0] CS_BUSY      = 4'h8;
    localparam logic [3:0] CS_TDMA_ACK  = 4'h9;
    localparam logic [3:0] CS_TAPE_RDY  = 4'ha;
    localparam logic [5:0] RESET_ADDR   = 6'h3f;
endpackage : dma_seq_pkg

//--- tb/disk_tape_dma_handshake_sequencer_test.sv
// self-checking testbench for the disk and tape dma handshake sequencer
module disk_tape_dma_handshake_sequencer_test
    import dma_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk, reset_n, cmd_valid, disk_req, disk_busy, disk_int_req;
    logic       tape_ack, tape_ready, tape_cmd_req, tape_exception, ch1_on, stray_ack;
    logic       disk_dma_ack, tape_dma_ack, cmd_ack, disk_dma_req, host_ready_extend;
    logic       host_int, disk_ack, disk_attn, disk_reset, node_match, tape_dma_req;
    logic       tape_xfer, tape_req, tape_online, tape_int, tape_reset, busy;
    logic [3:0] cmd_code, ack_delay;
    logic [7:0] disk_data, node_mask, exp_lat;
    logic [4:0] target_set, target_clr, target_lines;
    int         bad_count, cmp_count, acks;
    // 0 cmd ack, 1 ready, 2 disk dma req, 3 disk ack, 4 host int, 5 tape dma req, 6 xfer, 7 tape req
    wire logic [7:0] mon = {tape_req, tape_xfer, tape_dma_req, host_int,
                            disk_ack, disk_dma_req, host_ready_extend, cmd_ack};
    // latched lines in latch bit order
    wire logic [7:0] lat = {disk_ack, tape_reset, tape_int, tape_online,
                            tape_dma_req, host_int, disk_reset, disk_attn};
    localparam logic [2:0]  POS [13] = '{LB_ATTN, LB_ATTN, LB_DRESET, LB_DRESET, LB_HOST_INT,
        LB_TAPE_DREQ, LB_TAPE_DREQ, LB_ONLINE, LB_ONLINE, LB_TAPE_INT, LB_TAPE_INT,
        LB_TAPE_RST, LB_TAPE_RST};
    localparam logic [12:0] VAL      = 13'h0aa5;

    dma_sequencer dut (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_ack(cmd_ack), .disk_dma_ack(disk_dma_ack),
        .tape_dma_ack(tape_dma_ack), .disk_dma_req(disk_dma_req),
        .host_ready_extend(host_ready_extend), .host_int(host_int), .disk_req(disk_req),
        .disk_busy(disk_busy), .disk_data(disk_data), .node_mask(node_mask),
        .disk_int_req(disk_int_req), .disk_ack(disk_ack), .disk_attn(disk_attn),
        .disk_reset(disk_reset), .node_match(node_match), .target_set(target_set),
        .target_clr(target_clr), .target_lines(target_lines), .tape_ack(tape_ack),
        .tape_ready(tape_ready), .tape_cmd_req(tape_cmd_req),
        .tape_exception(tape_exception), .tape_dma_req(tape_dma_req),
        .tape_xfer(tape_xfer), .tape_req(tape_req), .tape_online(tape_online),
        .tape_int(tape_int), .tape_reset(tape_reset), .busy(busy));

    host_dma_model host (.clk(clk), .reset_n(reset_n), .ack_delay(ack_delay),
        .ch1_on(ch1_on), .stray_ack(stray_ack), .disk_dma_req(disk_dma_req),
        .host_ready_extend(host_ready_extend), .tape_dma_req(tape_dma_req),
        .disk_dma_ack(disk_dma_ack), .tape_dma_ack(tape_dma_ack));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // outputs are looked at on the falling edge, clear of the launch edge
    task automatic wait_bit(input int idx, input logic val, input int lim);
        for (int n = 0; n < lim && mon[idx] !== val; n++)
            @(negedge clk);
        check(8'(mon[idx]), 8'(val));
    endtask : wait_bit

    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask : cycles

    task automatic send_cmd(input logic [3:0] code);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_code  <= code;
        wait_bit(0, 1'b1, 40);
        @(posedge clk);
        cmd_valid <= 1'b0;
        cycles(4);
    endtask : send_cmd

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done

    // --------------------
    // watchdog
    // --------------------
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        test_done();
    end

    // --------------------
    // scenarios
    // --------------------
    initial begin
        {cmd_valid, disk_req, disk_int_req, tape_ack, tape_ready, tape_cmd_req} = '0;
        {tape_exception, ch1_on, stray_ack, reset_n} = '0;
        {cmd_code, disk_data, node_mask, target_set, target_clr, exp_lat} = '0;
        {bad_count, cmp_count, acks} = '0;
        disk_busy = 1'b1;
        ack_delay = 4'h1;
        repeat (9) @(posedge clk);
        @(negedge clk);
        check(mon | lat, 8'h00);
        @(posedge clk);
        reset_n <= 1'b1;
        cycles(3);
        check(mon | lat | 8'(target_lines), 8'h00);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            node_mask <= 8'h01 << i;
            disk_data <= 8'h01 << i;
            cycles(3);
            check(8'(node_match), 8'h01);
            @(posedge clk);
            disk_data <= ~(8'h01 << i);
            cycles(3);
            check(8'(node_match), 8'h00);
        end
        @(posedge clk);
        target_set <= 5'h15;
        @(posedge clk);
        target_set <= 5'h0b;
        target_clr <= 5'h11;
        @(posedge clk);
        target_set <= 5'h00;
        target_clr <= 5'h00;
        cycles(3);
        check(8'(target_lines), 8'h0e);
        @(posedge clk);
        disk_int_req <= 1'b1;
        wait_bit(4, 1'b1, 40);
        @(posedge clk);
        disk_int_req   <= 1'b0;
        tape_exception <= 1'b1;
        wait_bit(5, 1'b1, 40);
        @(posedge clk);
        tape_exception <= 1'b0;
        cycles(6);
        exp_lat = 8'h0c;
        check(lat, exp_lat);
        for (int c = 0; c <= int'(CMD_LAST); c++) begin
            send_cmd(4'(c));
            exp_lat[POS[c]] = VAL[c];
            check(lat, exp_lat);
        end
        for (int c = 13; c < 16; c++) begin
            @(posedge clk);
            cmd_valid <= 1'b1;
            cmd_code  <= 4'(c);
            repeat (30) begin
                @(negedge clk);
                if (cmd_ack !== 1'b0)
                    acks++;
            end
            @(posedge clk);
            cmd_valid <= 1'b0;
        end
        check(8'(acks), 8'h00);
        check(lat, 8'h00);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            ack_delay <= (k == 0) ? 4'h1 : 4'h6;
            disk_req  <= 1'b1;
            wait_bit(2, 1'b1, 40);
            @(posedge clk);
            disk_req <= 1'b0;
            if (k == 1) begin
                cycles(3);
                check(8'(mon[2:1]), 8'h02);
            end
            wait_bit(1, 1'b1, 20);
            check(8'(disk_dma_req), 8'h00);
            wait_bit(3, 1'b1, 10);
            cycles(3);
            check(8'(host_ready_extend), 8'h01);
            check(8'(busy), 8'h01);
            @(posedge clk);
            disk_req <= 1'b1;
            wait_bit(1, 1'b0, 10);
            @(posedge clk);
            disk_req <= 1'b0;
            wait_bit(3, 1'b0, 10);
            cycles(4);
        end
        @(posedge clk);
        disk_busy <= 1'b0;
        stray_ack <= 1'b1;
        wait_bit(1, 1'b1, 40);
        @(posedge clk);
        stray_ack <= 1'b0;
        cycles(5);
        check(8'(host_ready_extend), 8'h01);
        @(posedge clk);
        disk_busy <= 1'b1;
        wait_bit(1, 1'b0, 10);
        send_cmd(CMD_SET_ONLINE);
        check(8'(tape_online), 8'h01);
        @(posedge clk);
        ch1_on   <= 1'b1;
        tape_ack <= 1'b1;
        wait_bit(1, 1'b1, 40);
        wait_bit(5, 1'b1, 10);
        @(posedge clk);
        tape_ack <= 1'b0;
        wait_bit(5, 1'b0, 30);
        check(8'(host_ready_extend), 8'h00);
        cycles(4);
        send_cmd(CMD_SET_TDREQ);
        wait_bit(6, 1'b1, 40);
        @(posedge clk);
        tape_ack <= 1'b1;
        cycles(3);
        check(8'(tape_dma_req), 8'h01);
        @(posedge clk);
        tape_ack <= 1'b0;
        wait_bit(5, 1'b0, 20);
        check(8'(tape_xfer), 8'h00);
        @(posedge clk);
        ch1_on <= 1'b0;
        @(posedge clk);
        tape_cmd_req <= 1'b1;
        wait_bit(7, 1'b1, 40);
        check(8'(host_ready_extend), 8'h01);
        @(posedge clk);
        tape_cmd_req <= 1'b0;
        tape_ready   <= 1'b1;
        cycles(3);
        check(mon & 8'h82, 8'h00);
        @(posedge clk);
        tape_ready <= 1'b0;
        cycles(4);
        send_cmd(CMD_CLR_ONLINE);
        check(8'(tape_online), 8'h00);
        send_cmd(CMD_SET_ATTN);
        check(8'(disk_attn), 8'h01);
        test_done();
    end
endmodule : disk_tape_dma_handshake_sequencer_test

//--- tb/host_dma_model.sv
// host dma channel model answering the sequencer's disk and tape requests
module host_dma_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // scenario controls
    input  wire logic [3:0] ack_delay,
    input  wire logic       ch1_on,
    input  wire logic       stray_ack,
    // sequencer side
    input  wire logic       disk_dma_req,
    input  wire logic       host_ready_extend,
    input  wire logic       tape_dma_req,
    output logic            disk_dma_ack,
    output logic            tape_dma_ack
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       chip_select_one;
    logic       host_data_strobe;
    logic [3:0] wait0;
    logic [3:0] wait1;

    assign disk_dma_ack = chip_select_one & host_data_strobe;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            chip_select_one  <= 1'b0;
            host_data_strobe <= 1'b0;
            tape_dma_ack     <= 1'b0;
            wait0            <= 4'h0;
            wait1            <= 4'h0;
        end else begin
            // bus cycle stays open while the ready extension stands
            if (chip_select_one)
                chip_select_one <= disk_dma_req | host_ready_extend | stray_ack;
            else
                chip_select_one <= stray_ack | (disk_dma_req && wait0 >= ack_delay);
            host_data_strobe <= chip_select_one;
            wait0 <= (disk_dma_req && !chip_select_one) ? wait0 + 4'h1 : 4'h0;
            // channel 1 answers only when the scenario opens it
            if (tape_dma_ack)
                tape_dma_ack <= tape_dma_req;
            else
                tape_dma_ack <= ch1_on && tape_dma_req && wait1 >= ack_delay;
            wait1 <= (tape_dma_req && !tape_dma_ack) ? wait1 + 4'h1 : 4'h0;
        end
    end
endmodule : host_dma_model

//--- verilog/dma_sequencer.sv
// handshake sequencer for host dma, disk bus and tape port
// Operation
// - idle loop tests conditions, branches or advances
// - thirteen commands, one write, ack pulse
// - set writes one, clear writes zero
// - ack subroutine: ready until bus busy
// - disk request starts one-byte disk dma
// - request channel 0, wait host ack
// - drop request, ack, wait request, release
// - same disk routine for read, write
// - tape ack starts read on channel 1
// - channel 1 ack with request latched starts write
// - write strobe, wait tape ack high, low
// - tape command: ready, wait tape ready pulse
// - one-hot node address on data lines
// - node match is or of masked bits
// - target mode lines latched and driven
// - reset starts at S_RESET, clears outputs
// - latch address selects one bit written
module dma_sequencer
    import dma_seq_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // host command register
    input  wire logic       cmd_valid,
    input  wire logic [3:0] cmd_code,
    output logic            cmd_ack,
    // host dma
    input  wire logic       disk_dma_ack,
    input  wire logic       tape_dma_ack,
    output logic            disk_dma_req,
    output logic            host_ready_extend,
    output logic            host_int,
    // disk bus
    input  wire logic       disk_req,
    input  wire logic       disk_busy,
    input  wire logic [7:0] disk_data,
    input  wire logic [7:0] node_mask,
    input  wire logic       disk_int_req,
    output logic            disk_ack,
    output logic            disk_attn,
    output logic            disk_reset,
    output logic            node_match,
    // target mode lines
    input  wire logic [4:0] target_set,
    input  wire logic [4:0] target_clr,
    output logic      [4:0] target_lines,
    // tape port
    input  wire logic       tape_ack,
    input  wire logic       tape_ready,
    input  wire logic       tape_cmd_req,
    input  wire logic       tape_exception,
    output logic            tape_dma_req,
    output logic            tape_xfer,
    output logic            tape_req,
    output logic            tape_online,
    output logic            tape_int,
    output logic            tape_reset,
    // transfer status
    output logic            busy
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        S_RESET, S_IDLE_CMD, S_IDLE_DACK, S_IDLE_DREQ, S_IDLE_TACK, S_IDLE_TWR,
        S_IDLE_DACK2, S_IDLE_TCMD, S_IDLE_DINT, S_IDLE_TEXC, S_BUSY_WAIT,
        S_DD_REQ, S_DD_WAIT, S_RD_WAIT, S_WR_ACKHI, S_WR_ACKLO, S_WR_CLR,
        S_TC_RDYHI, S_TC_RDYLO, S_INT_TAPE
    } state_e;
    state_e state;
    state_e next_state;
    state_e ret_state;
    state_e next_ret;
    logic [7:0] latch_q;
    logic       lat_en;
    logic [2:0] lat_addr;
    logic       lat_set;
    logic       next_ready;
    logic       next_ddreq;
    logic       next_xfer;
    logic       next_treq;
    logic       next_ack;
    logic [3:0] cond_sel;
    logic       cond;
    // ------------------------------------------------------------
    // condition mux and node comparator
    // ------------------------------------------------------------
    function automatic logic pick(input logic [3:0] s, input logic [15:0] v);
        pick = v[s];
    endfunction : pick
    wire tape_wr_cond = tape_dma_ack && latch_q[LB_TAPE_DREQ];
    wire [15:0] cond_vec = {5'h00, tape_ready, tape_dma_ack, disk_busy,
                            tape_exception, disk_int_req, tape_cmd_req, tape_wr_cond,
                            tape_ack, disk_req, disk_dma_ack, cmd_valid};
    wire node_hit = |(disk_data & node_mask);
    wire cmd_ok   = cmd_code <= CMD_LAST;
    assign cond = pick(cond_sel, cond_vec);
    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_ret   = ret_state;
        cond_sel   = CS_CMD_VALID;
        lat_en     = 1'b0;
        lat_addr   = 3'h0;
        lat_set    = 1'b0;
        next_ready = 1'b0;
        next_ddreq = 1'b0;
        next_xfer  = 1'b0;
        next_treq  = 1'b0;
        next_ack   = 1'b0;
        case (state)
            S_RESET: next_state = S_IDLE_CMD;
            S_IDLE_CMD: begin
                cond_sel = CS_CMD_VALID;
                if (cond && cmd_ok) begin
                    lat_en     = 1'b1;
                    // low codes set on even, high codes set on odd; code 4 only clears
                    lat_set    = (cmd_code == CMD_CLR_INT) ? 1'b0
                               : (cmd_code < CMD_CLR_INT) ? ~cmd_code[0] : cmd_code[0];
                    lat_addr   = (cmd_code <= CMD_CLR_DRST) ? 3'(cmd_code >> 1)
                               : (cmd_code == CMD_CLR_INT) ? LB_HOST_INT
                               : 3'((cmd_code - 4'h5) >> 1) + LB_TAPE_DREQ;
                    next_ack   = 1'b1;
                    // move on so a valid flag still standing is not run twice
                    next_state = S_IDLE_DACK;
                end else begin
                    next_state = S_IDLE_DACK;
                end
            end
            S_IDLE_DACK, S_IDLE_DACK2: begin
                cond_sel = CS_DDMA_ACK;
                next_ret = (state == S_IDLE_DACK) ? S_IDLE_DREQ : S_IDLE_TCMD;
                next_state = cond ? S_BUSY_WAIT : next_ret;
            end
            S_IDLE_DREQ: begin
                cond_sel   = CS_DISK_REQ;
                next_state = cond ? S_DD_REQ : S_IDLE_TACK;
            end
            S_IDLE_TACK: begin
                cond_sel = CS_TAPE_ACK;
                if (cond) begin
                    lat_en     = 1'b1;
                    lat_addr   = LB_TAPE_DREQ;
                    lat_set    = 1'b1;
                    next_ready = 1'b1;
                    next_state = S_RD_WAIT;
                end else begin
                    next_state = S_IDLE_TWR;
                end
            end
            S_IDLE_TWR: begin
                cond_sel = CS_TAPE_WR;
                if (cond) begin
                    next_xfer  = 1'b1;
                    next_state = S_WR_ACKHI;
                end else begin
                    next_state = S_IDLE_DACK2;
                end
            end
            S_IDLE_TCMD: begin
                cond_sel = CS_TAPE_CMD;
                if (cond) begin
                    next_ready = 1'b1;
                    next_treq  = 1'b1;
                    next_state = S_TC_RDYHI;
                end else begin
                    next_state = S_IDLE_DINT;
                end
            end
            S_IDLE_DINT: begin
                cond_sel = CS_DISK_INT;
                if (cond) begin
                    lat_en   = 1'b1;
                    lat_addr = LB_HOST_INT;
                    lat_set  = 1'b1;
                    next_state = S_IDLE_CMD;
                end else begin
                    next_state = S_IDLE_TEXC;
                end
            end
            S_IDLE_TEXC: begin
                cond_sel = CS_TAPE_EXC;
                if (cond) begin
                    lat_en   = 1'b1;
                    lat_addr = LB_HOST_INT;
                    lat_set  = 1'b1;
                    next_state = S_INT_TAPE;
                end else begin
                    next_state = S_IDLE_CMD;
                end
            end
            S_INT_TAPE: begin
                lat_en     = 1'b1;
                lat_addr   = LB_TAPE_DREQ;
                lat_set    = 1'b1;
                next_state = S_IDLE_CMD;
            end
            S_BUSY_WAIT: begin
                cond_sel   = CS_BUSY;
                next_ready = ~cond;
                if (cond) next_state = ret_state;
            end
            S_DD_REQ: begin
                cond_sel   = CS_DDMA_ACK;
                next_ddreq = ~cond;
                if (cond) begin
                    next_ready = 1'b1;
                    lat_en     = 1'b1;
                    lat_addr   = LB_DISK_ACK;
                    lat_set    = 1'b1;
                    next_state = S_DD_WAIT;
                end
            end
            S_DD_WAIT: begin
                cond_sel   = CS_DISK_REQ;
                next_ready = ~cond;
                if (cond) begin
                    lat_en     = 1'b1;
                    lat_addr   = LB_DISK_ACK;
                    next_state = S_IDLE_CMD;
                end
            end
            S_RD_WAIT: begin
                cond_sel   = CS_TDMA_ACK;
                next_ready = ~cond;
                if (cond) begin
                    lat_en     = 1'b1;
                    lat_addr   = LB_TAPE_DREQ;
                    next_state = S_IDLE_CMD;
                end
            end
            S_WR_ACKHI: begin
                cond_sel   = CS_TAPE_ACK;
                next_xfer  = 1'b1;
                if (cond) next_state = S_WR_ACKLO;
            end
            S_WR_ACKLO: begin
                cond_sel = CS_TAPE_ACK;
                if (!cond) next_state = S_WR_CLR;
            end
            S_WR_CLR: begin
                lat_en     = 1'b1;
                lat_addr   = LB_TAPE_DREQ;
                next_state = S_IDLE_CMD;
            end
            S_TC_RDYHI: begin
                cond_sel   = CS_TAPE_RDY;
                next_ready = 1'b1;
                next_treq  = 1'b1;
                if (cond) next_state = S_TC_RDYLO;
            end
            S_TC_RDYLO: begin
                cond_sel = CS_TAPE_RDY;
                if (!cond) next_state = S_IDLE_CMD;
            end
            default: next_state = S_RESET;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state             <= S_RESET;
            ret_state         <= S_IDLE_DREQ;
            host_ready_extend <= 1'b0;
            disk_dma_req      <= 1'b0;
            tape_xfer         <= 1'b0;
            tape_req          <= 1'b0;
            cmd_ack           <= 1'b0;
            node_match        <= 1'b0;
            busy              <= 1'b0;
            target_lines      <= 5'h00;
        end else begin
            state             <= next_state;
            ret_state         <= next_ret;
            host_ready_extend <= next_ready;
            disk_dma_req      <= next_ddreq || (state == S_IDLE_DREQ && cond);
            tape_xfer         <= next_xfer;
            tape_req          <= next_treq;
            cmd_ack           <= next_ack;
            node_match        <= node_hit;
            busy              <= next_state != S_IDLE_CMD;
            target_lines      <= (target_lines | target_set) & ~target_clr;
        end
    end

    output_latch u_latch (
        .clk         (clk),
        .reset_n     (reset_n),
        .latch_clear (state == S_RESET),
        .enable      (lat_en),
        .addr        (lat_addr),
        .set_value   (lat_set),
        .q           (latch_q)
    );
    // latched lines re-registered so outputs come from flip-flops
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            {disk_ack, tape_reset, tape_int, tape_online} <= 4'h0;
            {tape_dma_req, host_int, disk_reset, disk_attn} <= 4'h0;
        end else begin
            {disk_ack, tape_reset, tape_int, tape_online} <= latch_q[7:4];
            {tape_dma_req, host_int, disk_reset, disk_attn} <= latch_q[3:0];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_reset_start: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(reset_n) |-> state == S_RESET) else $error("reset not at start");
    chk_cmd_ack: assert property (@(posedge clk) disable iff (!reset_n)
        state == S_IDLE_CMD && cmd_valid && cmd_ok |=> cmd_ack) else $error("cmd not acked");
    chk_ddreq_drop: assert property (@(posedge clk) disable iff (!reset_n)
        state == S_DD_REQ && disk_dma_ack |=> !disk_dma_req && host_ready_extend)
        else $error("disk request not dropped");
    chk_dd_done: assert property (@(posedge clk) disable iff (!reset_n)
        state == S_DD_WAIT && disk_req |=> state == S_IDLE_CMD) else $error("disk not done");
    chk_node_match: assert property (@(posedge clk) disable iff (!reset_n)
        ##1 node_match == |($past(disk_data) & $past(node_mask))) else $error("node match");
    sequence wr_start; state == S_IDLE_TWR && tape_wr_cond; endsequence
    chk_wr_strobe: assert property (@(posedge clk) disable iff (!reset_n)
        wr_start |=> tape_xfer) else $error("write strobe missing");
    chk_tc_ready: assert property (@(posedge clk) disable iff (!reset_n)
        state == S_IDLE_TCMD && tape_cmd_req |=> host_ready_extend && tape_req)
        else $error("tape command lines");
    chk_busy_wait: assert property (@(posedge clk) disable iff (!reset_n)
        state == S_BUSY_WAIT && !disk_busy |=> host_ready_extend) else $error("ready dropped");
    chk_idle_adv: assert property (@(posedge clk) disable iff (!reset_n)
        state == S_IDLE_DREQ && !disk_req |=> state == S_IDLE_TACK) else $error("no advance");
endmodule : dma_sequencer

//--- verilog/output_latch.sv
// addressable eight-bit output latch
module output_latch
    import dma_seq_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // write port
    input  wire logic       latch_clear,
    input  wire logic       enable,
    input  wire logic [2:0] addr,
    input  wire logic       set_value,
    // latched lines
    output logic      [7:0] q
);
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (!reset_n || latch_clear) begin
                    q[i] <= LATCH_RESET[i];
                end else if (enable && addr == 3'(i)) begin
                    q[i] <= set_value;
                end
            end
        end
    endgenerate
endmodule : output_latch
